// >>> iorsa_bank.sv
`timescale 1ns/1ps
// How it works
// - Bit set and clear reach only I/O addresses 0x00 to 0x1F.
// - Skip tests of one bit work on the bit-accessible registers.
// - Interrupt flags clear on a written one; a written zero keeps them.
// - Bit set or clear touches only the addressed bit; a bit set on a flag register clears just that flag.
// - I/O read and write instructions use I/O addresses 0x00 to 0x3F.
// - Load and store reach each I/O register at its address plus 0x20.
// - Data addresses 0x60 to 0xFF are reachable only by load and store.
// - The I/O instruction address field holds exactly 64 locations.
module iorsa_bank (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Core access
    input wire iorsa_pkg::iorsa_req_t req_in,
    output iorsa_pkg::iorsa_resp_t resp_out,
    // Port pins
    input wire iorsa_pkg::iorsa_port_t pin_in,
    output iorsa_pkg::iorsa_port_t port_drive_out,
    output iorsa_pkg::iorsa_port_t port_dir_out,
    // Flag events and state
    input wire iorsa_pkg::iorsa_flags_t flag_set_in,
    output iorsa_pkg::iorsa_flags_t flags_out,
    output logic [7:0] ext_irq_mask_out
);

    function automatic logic is_byte_write(input iorsa_pkg::iorsa_cmd_t cmd);
        is_byte_write = (cmd == iorsa_pkg::IORSA_CMD_IO_WRITE) ||
                        (cmd == iorsa_pkg::IORSA_CMD_DATA_STORE);
    endfunction

    function automatic logic [7:0] rw_next(input logic [7:0] old,
                                           input iorsa_pkg::iorsa_cmd_t cmd,
                                           input logic [7:0] bitm,
                                           input logic [7:0] wdata,
                                           input logic [7:0] mask);
        if (is_byte_write(cmd)) begin
            rw_next = wdata & mask;
        end else if (cmd == iorsa_pkg::IORSA_CMD_SET_BIT) begin
            rw_next = (old | bitm) & mask;
        end else if (cmd == iorsa_pkg::IORSA_CMD_CLEAR_BIT) begin
            rw_next = old & ~bitm & mask;
        end else begin
            rw_next = old;
        end
    endfunction

    // Ones written, as seen by a flag register
    function automatic logic [7:0] w1c_clear(input iorsa_pkg::iorsa_cmd_t cmd,
                                             input logic [7:0] bitm,
                                             input logic [7:0] wdata,
                                             input logic [7:0] mask);
        if (is_byte_write(cmd)) begin
            w1c_clear = wdata & mask;
        end else if (cmd == iorsa_pkg::IORSA_CMD_SET_BIT) begin
            // Only the addressed flag, others are not written back
            w1c_clear = bitm & mask;
        end else begin
            w1c_clear = 8'h00;
        end
    endfunction

    iorsa_pkg::iorsa_port_t pin_meta_q;
    iorsa_pkg::iorsa_port_t pin_sync_q;
    iorsa_pkg::iorsa_port_t drive_q;
    iorsa_pkg::iorsa_port_t dir_q;
    iorsa_pkg::iorsa_flags_t flags_q;
    logic [7:0] mask_q;
    iorsa_pkg::iorsa_resp_t resp_q;
    iorsa_pkg::iorsa_flags_t flag_clr;

    logic io_hit;
    logic ext_hit;
    logic refused;
    logic [5:0] io_idx;
    logic [7:0] bitm;
    logic [7:0] rd_val;
    logic [7:0] data_rel;
    iorsa_pkg::iorsa_cmd_t cmd;

    assign cmd = req_in.valid ? req_in.cmd : iorsa_pkg::IORSA_CMD_NONE;
    assign bitm = 8'h01 << req_in.bit_sel;
    assign data_rel = req_in.addr - iorsa_pkg::IORSA_DATA_OFFSET;

    // Address decode per access kind
    always_comb begin
        io_hit = 1'b0;
        ext_hit = 1'b0;
        refused = 1'b0;
        io_idx = 6'h00;
        case (cmd)
            iorsa_pkg::IORSA_CMD_IO_READ,
            iorsa_pkg::IORSA_CMD_IO_WRITE: begin
                // Six-bit field, 64 locations only
                if (req_in.addr > iorsa_pkg::IORSA_IO_LAST) begin
                    refused = 1'b1;
                end else begin
                    io_hit = 1'b1;
                    io_idx = req_in.addr[5:0];
                end
            end
            iorsa_pkg::IORSA_CMD_DATA_LOAD,
            iorsa_pkg::IORSA_CMD_DATA_STORE: begin
                if (req_in.addr < iorsa_pkg::IORSA_DATA_OFFSET) begin
                    refused = 1'b1;
                end else if (req_in.addr >= iorsa_pkg::IORSA_EXT_FIRST) begin
                    ext_hit = 1'b1;
                end else begin
                    io_hit = 1'b1;
                    io_idx = data_rel[5:0];
                end
            end
            iorsa_pkg::IORSA_CMD_SET_BIT,
            iorsa_pkg::IORSA_CMD_CLEAR_BIT,
            iorsa_pkg::IORSA_CMD_SKIP_IF_SET,
            iorsa_pkg::IORSA_CMD_SKIP_IF_CLEAR: begin
                if (req_in.addr > iorsa_pkg::IORSA_BIT_LAST) begin
                    refused = 1'b1;
                end else begin
                    io_hit = 1'b1;
                    io_idx = req_in.addr[5:0];
                end
            end
            default: begin
                io_hit = 1'b0;
            end
        endcase
    end

    // Read mux; anything not listed reads zero
    always_comb begin
        rd_val = 8'h00;
        if (!io_hit) begin
            rd_val = 8'h00;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_B_PIN_INPUT) begin
            rd_val = pin_sync_q.b & iorsa_pkg::IORSA_PORT_B_MASK;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_B_DIRECTION) begin
            rd_val = dir_q.b;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_B_OUTPUT) begin
            rd_val = drive_q.b;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_C_PIN_INPUT) begin
            rd_val = pin_sync_q.c & iorsa_pkg::IORSA_PORT_C_MASK;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_C_DIRECTION) begin
            rd_val = dir_q.c;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_C_OUTPUT) begin
            rd_val = drive_q.c;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_D_PIN_INPUT) begin
            rd_val = pin_sync_q.d & iorsa_pkg::IORSA_PORT_D_MASK;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_D_DIRECTION) begin
            rd_val = dir_q.d;
        end else if (io_idx == iorsa_pkg::IORSA_PORT_D_OUTPUT) begin
            rd_val = drive_q.d;
        end else if (io_idx == iorsa_pkg::IORSA_TIMER0_IRQ_FLAGS) begin
            rd_val = flags_q.timer0;
        end else if (io_idx == iorsa_pkg::IORSA_TIMER1_IRQ_FLAGS) begin
            rd_val = flags_q.timer1;
        end else if (io_idx == iorsa_pkg::IORSA_TIMER2_IRQ_FLAGS) begin
            rd_val = flags_q.timer2;
        end else if (io_idx == iorsa_pkg::IORSA_PIN_CHANGE_IRQ_FLAGS) begin
            rd_val = flags_q.pin_change;
        end else if (io_idx == iorsa_pkg::IORSA_EXTERNAL_IRQ_FLAGS) begin
            rd_val = flags_q.external;
        end else if (io_idx == iorsa_pkg::IORSA_EXTERNAL_IRQ_MASK) begin
            rd_val = mask_q;
        end
    end

    function automatic logic hit(input logic any, input logic [5:0] idx,
                                 input logic [5:0] off);
        hit = any && (idx == off);
    endfunction

    // Pin synchroniser, second stage is the only reader of the first
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Port output and direction registers; writes to unused addresses fall through
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drive_q <= {3{iorsa_pkg::IORSA_REG_RESET}};
            dir_q <= {3{iorsa_pkg::IORSA_REG_RESET}};
        end else begin
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_B_OUTPUT)) begin
                drive_q.b <= rw_next(drive_q.b, cmd, bitm, req_in.wdata,
                                     iorsa_pkg::IORSA_PORT_B_MASK);
            end
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_C_OUTPUT)) begin
                drive_q.c <= rw_next(drive_q.c, cmd, bitm, req_in.wdata,
                                     iorsa_pkg::IORSA_PORT_C_MASK);
            end
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_D_OUTPUT)) begin
                drive_q.d <= rw_next(drive_q.d, cmd, bitm, req_in.wdata,
                                     iorsa_pkg::IORSA_PORT_D_MASK);
            end
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_B_DIRECTION)) begin
                dir_q.b <= rw_next(dir_q.b, cmd, bitm, req_in.wdata,
                                   iorsa_pkg::IORSA_PORT_B_MASK);
            end
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_C_DIRECTION)) begin
                dir_q.c <= rw_next(dir_q.c, cmd, bitm, req_in.wdata,
                                   iorsa_pkg::IORSA_PORT_C_MASK);
            end
            if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PORT_D_DIRECTION)) begin
                dir_q.d <= rw_next(dir_q.d, cmd, bitm, req_in.wdata,
                                   iorsa_pkg::IORSA_PORT_D_MASK);
            end
        end
    end

    // External interrupt enable mask
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_q <= iorsa_pkg::IORSA_REG_RESET;
        end else if (hit(io_hit, io_idx, iorsa_pkg::IORSA_EXTERNAL_IRQ_MASK)) begin
            mask_q <= rw_next(mask_q, cmd, bitm, req_in.wdata,
                              iorsa_pkg::IORSA_EXT_IRQ_MASK);
        end
    end

    // Ones that clear each flag register in this cycle
    always_comb begin
        flag_clr = '0;
        if (hit(io_hit, io_idx, iorsa_pkg::IORSA_TIMER0_IRQ_FLAGS)) begin
            flag_clr.timer0 = w1c_clear(cmd, bitm, req_in.wdata,
                                        iorsa_pkg::IORSA_TIMER0_MASK);
        end
        if (hit(io_hit, io_idx, iorsa_pkg::IORSA_TIMER1_IRQ_FLAGS)) begin
            flag_clr.timer1 = w1c_clear(cmd, bitm, req_in.wdata,
                                        iorsa_pkg::IORSA_TIMER1_MASK);
        end
        if (hit(io_hit, io_idx, iorsa_pkg::IORSA_TIMER2_IRQ_FLAGS)) begin
            flag_clr.timer2 = w1c_clear(cmd, bitm, req_in.wdata,
                                        iorsa_pkg::IORSA_TIMER2_MASK);
        end
        if (hit(io_hit, io_idx, iorsa_pkg::IORSA_PIN_CHANGE_IRQ_FLAGS)) begin
            flag_clr.pin_change = w1c_clear(cmd, bitm, req_in.wdata,
                                            iorsa_pkg::IORSA_PIN_CHANGE_MASK);
        end
        if (hit(io_hit, io_idx, iorsa_pkg::IORSA_EXTERNAL_IRQ_FLAGS)) begin
            flag_clr.external = w1c_clear(cmd, bitm, req_in.wdata,
                                          iorsa_pkg::IORSA_EXT_IRQ_MASK);
        end
    end

    // Sticky flags; an event in the clearing cycle survives the clear
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q <= {5{iorsa_pkg::IORSA_REG_RESET}};
        end else begin
            flags_q.timer0 <= (flags_q.timer0 & ~flag_clr.timer0) |
                (flag_set_in.timer0 & iorsa_pkg::IORSA_TIMER0_MASK);
            flags_q.timer1 <= (flags_q.timer1 & ~flag_clr.timer1) |
                (flag_set_in.timer1 & iorsa_pkg::IORSA_TIMER1_MASK);
            flags_q.timer2 <= (flags_q.timer2 & ~flag_clr.timer2) |
                (flag_set_in.timer2 & iorsa_pkg::IORSA_TIMER2_MASK);
            flags_q.pin_change <= (flags_q.pin_change & ~flag_clr.pin_change) |
                (flag_set_in.pin_change & iorsa_pkg::IORSA_PIN_CHANGE_MASK);
            flags_q.external <= (flags_q.external & ~flag_clr.external) |
                (flag_set_in.external & iorsa_pkg::IORSA_EXT_IRQ_MASK);
        end
    end

    // Answer one cycle after the request, showing state before the write
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            resp_q <= '0;
        end else begin
            resp_q.valid <= req_in.valid;
            resp_q.refused <= refused;
            resp_q.ext_hit <= ext_hit;
            if (cmd == iorsa_pkg::IORSA_CMD_IO_READ ||
                cmd == iorsa_pkg::IORSA_CMD_DATA_LOAD) begin
                resp_q.rdata <= rd_val;
            end else begin
                resp_q.rdata <= 8'h00;
            end
            if (cmd == iorsa_pkg::IORSA_CMD_SKIP_IF_SET) begin
                resp_q.skip <= io_hit && ((rd_val & bitm) != 8'h00);
            end else if (cmd == iorsa_pkg::IORSA_CMD_SKIP_IF_CLEAR) begin
                resp_q.skip <= io_hit && ((rd_val & bitm) == 8'h00);
            end else begin
                resp_q.skip <= 1'b0;
            end
        end
    end

    assign resp_out = resp_q;
    assign port_drive_out = drive_q;
    assign port_dir_out = dir_q;
    assign flags_out = flags_q;
    assign ext_irq_mask_out = mask_q;

endmodule

// >>> iorsa_pkg.sv
package iorsa_pkg;

    localparam int unsigned IORSA_DATA_W = 8;
    localparam int unsigned IORSA_IO_ADDR_W = 6;

    // Reachable windows
    localparam logic [7:0] IORSA_IO_LAST = 8'h3f;
    localparam logic [7:0] IORSA_BIT_LAST = 8'h1f;
    localparam logic [7:0] IORSA_DATA_OFFSET = 8'h20;
    localparam logic [7:0] IORSA_EXT_FIRST = 8'h60;
    localparam logic [7:0] IORSA_EXT_LAST = 8'hff;
    localparam int unsigned IORSA_IO_LOCATIONS = 64;

    // I/O addresses
    localparam logic [5:0] IORSA_PORT_B_PIN_INPUT = 6'h03;
    localparam logic [5:0] IORSA_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] IORSA_PORT_B_OUTPUT = 6'h05;
    localparam logic [5:0] IORSA_PORT_C_PIN_INPUT = 6'h06;
    localparam logic [5:0] IORSA_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] IORSA_PORT_C_OUTPUT = 6'h08;
    localparam logic [5:0] IORSA_PORT_D_PIN_INPUT = 6'h09;
    localparam logic [5:0] IORSA_PORT_D_DIRECTION = 6'h0a;
    localparam logic [5:0] IORSA_PORT_D_OUTPUT = 6'h0b;
    localparam logic [5:0] IORSA_TIMER0_IRQ_FLAGS = 6'h15;
    localparam logic [5:0] IORSA_TIMER1_IRQ_FLAGS = 6'h16;
    localparam logic [5:0] IORSA_TIMER2_IRQ_FLAGS = 6'h17;
    localparam logic [5:0] IORSA_PIN_CHANGE_IRQ_FLAGS = 6'h1b;
    localparam logic [5:0] IORSA_EXTERNAL_IRQ_FLAGS = 6'h1c;
    localparam logic [5:0] IORSA_EXTERNAL_IRQ_MASK = 6'h1d;

    // Implemented bit masks
    localparam logic [7:0] IORSA_PORT_B_MASK = 8'hff;
    localparam logic [7:0] IORSA_PORT_C_MASK = 8'h7f;
    localparam logic [7:0] IORSA_PORT_D_MASK = 8'hff;
    localparam logic [7:0] IORSA_TIMER0_MASK = 8'h07;
    localparam logic [7:0] IORSA_TIMER1_MASK = 8'h27;
    localparam logic [7:0] IORSA_TIMER2_MASK = 8'h07;
    localparam logic [7:0] IORSA_PIN_CHANGE_MASK = 8'h07;
    localparam logic [7:0] IORSA_EXT_IRQ_MASK = 8'h03;

    // Reset values
    localparam logic [7:0] IORSA_REG_RESET = 8'h00;

    typedef enum logic [7:0] {
        IORSA_CMD_NONE = 8'h00,
        IORSA_CMD_IO_READ = 8'h01,
        IORSA_CMD_IO_WRITE = 8'h02,
        IORSA_CMD_DATA_LOAD = 8'h04,
        IORSA_CMD_DATA_STORE = 8'h08,
        IORSA_CMD_SET_BIT = 8'h10,
        IORSA_CMD_CLEAR_BIT = 8'h20,
        IORSA_CMD_SKIP_IF_SET = 8'h40,
        IORSA_CMD_SKIP_IF_CLEAR = 8'h80
    } iorsa_cmd_t;

    typedef struct packed {
        logic valid;
        iorsa_cmd_t cmd;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iorsa_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic skip;
        logic refused;
        logic ext_hit;
    } iorsa_resp_t;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } iorsa_port_t;

    typedef struct packed {
        logic [7:0] timer0;
        logic [7:0] timer1;
        logic [7:0] timer2;
        logic [7:0] pin_change;
        logic [7:0] external;
    } iorsa_flags_t;

endpackage

// >>> iorsa_bank_monitor.sv
`timescale 1ns/1ps
module iorsa_bank_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Core access
    input wire iorsa_pkg::iorsa_req_t req_in,
    input wire iorsa_pkg::iorsa_resp_t resp_out,
    // Port pins
    input wire iorsa_pkg::iorsa_port_t pin_in,
    input wire iorsa_pkg::iorsa_port_t port_drive_out,
    input wire iorsa_pkg::iorsa_port_t port_dir_out,
    // Flags
    input wire iorsa_pkg::iorsa_flags_t flag_set_in,
    input wire iorsa_pkg::iorsa_flags_t flags_out,
    input wire logic [7:0] ext_irq_mask_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // One-hot codes, so single bits name the command
    wire [7:0] c = req_in.cmd;
    wire v = req_in.valid;
    wire [7:0] a = req_in.addr;
    sequence s_t0_clear;
        v && c[1] && a == 8'h15 && req_in.wdata[0] && !flag_set_in.timer0[0];
    endsequence
    sequence s_set_b;
        v && c[4] && a == 8'h05;
    endsequence
    chk_answer_next_cycle: assert property (v |=> resp_out.valid)
        else $error("no answer one cycle after request");
    chk_idle_no_answer: assert property (!v |=> !resp_out.valid)
        else $error("answer without request");
    chk_io_range_refuse: assert property (
        v && |c[1:0] && a > 8'h3f |=> resp_out.refused)
        else $error("I/O access above 0x3f not refused");
    chk_bit_range_refuse: assert property (
        v && |c[7:4] && a > 8'h1f |=> resp_out.refused && !resp_out.skip)
        else $error("bit access above 0x1f not refused");
    chk_ext_region_hit: assert property (
        v && |c[3:2] && a >= 8'h60
        |=> resp_out.ext_hit && !resp_out.refused && resp_out.rdata == 8'h00)
        else $error("extended region access wrong");
    chk_load_offset_map: assert property (
        v && c[2] && a == 8'h25 |=> resp_out.rdata == $past(port_drive_out.b))
        else $error("load at 0x25 wrong data");
    chk_flag_set_sticky: assert property (
        flag_set_in.timer0[0] |=> flags_out.timer0[0])
        else $error("flag set pulse lost");
    chk_flag_one_clears: assert property (s_t0_clear |=> !flags_out.timer0[0])
        else $error("written one did not clear flag");
    chk_flag_zero_keeps: assert property (
        v && c[1] && a == 8'h1c && !req_in.wdata[0] && flags_out.external[0]
        |=> flags_out.external[0]) else $error("written zero cleared flag");
    chk_bit_set_only: assert property (
        s_set_b |=> port_drive_out.b ==
        ($past(port_drive_out.b) | (8'h01 << $past(req_in.bit_sel))))
        else $error("bit set disturbed other bits");
    chk_clear_bit_flags: assert property (
        v && c[5] && a == 8'h15 && flag_set_in.timer0 == 8'h00
        |=> $stable(flags_out.timer0)) else $error("bit clear changed flags");
    chk_skip_only_cmd: assert property (v && !(|c[7:6]) |=> !resp_out.skip)
        else $error("skip raised by non-skip command");
    chk_unused_bits_zero: assert property (
        port_drive_out.c[7] == 1'b0 && port_dir_out.c[7] == 1'b0
        && ext_irq_mask_out[7:2] == 6'h00)
        else $error("unused bit not zero");
endmodule

bind iorsa_bank iorsa_bank_monitor u_iorsa_bank_monitor (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .req_in(req_in), .resp_out(resp_out), .pin_in(pin_in),
    .port_drive_out(port_drive_out), .port_dir_out(port_dir_out), .flag_set_in(flag_set_in),
    .flags_out(flags_out), .ext_irq_mask_out(ext_irq_mask_out));

// >>> iorsa_core_model.sv
`timescale 1ns/1ps
module iorsa_core_model (
    // Clock
    input wire logic clk_in,
    // Core access
    output iorsa_pkg::iorsa_req_t req_out,
    input wire iorsa_pkg::iorsa_resp_t resp_in
);
    initial req_out = '0;
    function automatic logic [7:0] used_bits(input logic [5:0] io);
        case (io)
            6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b: used_bits = 8'hff;
            6'h06, 6'h07, 6'h08: used_bits = iorsa_pkg::IORSA_PORT_C_MASK;
            6'h15, 6'h17, 6'h1b: used_bits = 8'h07;
            6'h16: used_bits = iorsa_pkg::IORSA_TIMER1_MASK;
            6'h1c, 6'h1d: used_bits = iorsa_pkg::IORSA_EXT_IRQ_MASK;
            default: used_bits = 8'h00;
        endcase
    endfunction
    // Request held one cycle; the answer stands in the cycle after it is taken
    task automatic access(input iorsa_pkg::iorsa_cmd_t cmd, input logic [7:0] addr,
            input logic [2:0] bit_sel, input logic [7:0] wdata,
            output iorsa_pkg::iorsa_resp_t resp);
        logic [7:0] io;
        logic [7:0] m;
        io = (cmd == iorsa_pkg::IORSA_CMD_DATA_STORE) ? addr - 8'h20 : addr;
        m = used_bits(io[5:0]);
        if (io <= 8'h3f && (cmd == iorsa_pkg::IORSA_CMD_IO_WRITE
                || cmd == iorsa_pkg::IORSA_CMD_DATA_STORE)) begin
            wdata = wdata & m;
            if (m == 8'h00)
                cmd = iorsa_pkg::IORSA_CMD_NONE;
        end
        @(posedge clk_in);
        req_out <= '{1'b1, cmd, addr, bit_sel, wdata};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        resp = resp_in;
    endtask
endmodule

// >>> test_io_register_space_access.sv
`timescale 1ns/1ps
module test_io_register_space_access;
    localparam logic [7:0] RW_ADDR [7] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h1d};
    localparam logic [7:0] BAD_CMD [11] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80, 8'h04,
        8'h08, 8'h04, 8'h08, 8'h04};
    localparam logic [7:0] BAD_ADDR [11] = '{8'h40, 8'hff, 8'h20, 8'h3f, 8'h20, 8'hff, 8'h1f,
        8'h00, 8'h60, 8'hff, 8'h5f};
    localparam logic [1:0] BAD_CODE [11] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h1, 2'h1, 2'h0};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    iorsa_pkg::iorsa_req_t req;
    iorsa_pkg::iorsa_resp_t resp;
    iorsa_pkg::iorsa_port_t pin_in = '0;
    iorsa_pkg::iorsa_port_t drive;
    iorsa_pkg::iorsa_port_t dir;
    iorsa_pkg::iorsa_flags_t flag_set_in = '0;
    iorsa_pkg::iorsa_flags_t flags;
    logic [7:0] irq_mask;
    iorsa_pkg::iorsa_resp_t r;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] exp_v;
    wire [55:0] rw_regs = {dir.b, drive.b, dir.c, drive.c, dir.d, drive.d, irq_mask};
    `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
    always #10 clk_in = ~clk_in;
    iorsa_bank u_iorsa_bank (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req),
        .resp_out(resp), .pin_in(pin_in), .port_drive_out(drive), .port_dir_out(dir),
        .flag_set_in(flag_set_in), .flags_out(flags), .ext_irq_mask_out(irq_mask));
    iorsa_core_model u_iorsa_core_model (.clk_in(clk_in), .req_out(req), .resp_in(resp));
    task automatic acc(input logic [7:0] cmd, input logic [7:0] addr, input logic [2:0] b,
            input logic [7:0] wdata);
        u_iorsa_core_model.access(iorsa_pkg::iorsa_cmd_t'(cmd), addr, b, wdata, r);
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        acc(8'h01, addr, 3'h0, 8'h00);
        `CHK({r.refused, r.rdata}, {1'b0, exp})
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_in);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // Every one of the 64 I/O places reads zero after reset
        for (int i = 0; i < 64; i++)
            rd_chk(8'(i), 8'h00);
        for (int i = 0; i < 7; i++)
            acc(8'h02, RW_ADDR[i], 3'h0, 8'ha5 + 8'(i));
        for (int i = 0; i < 7; i++) begin
            acc(8'h04, RW_ADDR[i] + 8'h20, 3'h0, 8'h00);
            exp_v = (i == 2 || i == 3) ? 8'h7f : (i == 6) ? 8'h03 : 8'hff;
            `CHK(r.rdata, (8'ha5 + 8'(i)) & exp_v)
        end
        `CHK(rw_regs, 56'ha5_a627_28a9_aa03)
        @(posedge clk_in);
        pin_in <= '{b: 8'h5a, c: 8'hb5, d: 8'hc3};
        acc(8'h02, 8'h03, 3'h0, 8'hff);
        repeat (3) @(posedge clk_in);
        rd_chk(8'h03, 8'h5a);
        rd_chk(8'h06, 8'h35);
        rd_chk(8'h09, 8'hc3);
        for (int i = 0; i < 8; i++) begin
            acc(8'h40, 8'h03, 3'(i), 8'h00);
            `CHK(r.skip, 8'h5a >> i & 8'h01)
            acc(8'h80, 8'h03, 3'(i), 8'h00);
            `CHK(r.skip, ~(8'h5a >> i) & 8'h01)
        end
        acc(8'h20, 8'h05, 3'h1, 8'h00);
        acc(8'h10, 8'h05, 3'h0, 8'h00);
        `CHK(drive.b, 8'ha5)
        acc(8'h10, 8'h1f, 3'h7, 8'h00);
        `CHK({r.refused, r.skip}, 2'h0)
        @(posedge clk_in);
        flag_set_in <= '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03};
        @(posedge clk_in);
        flag_set_in <= '0;
        @(posedge clk_in);
        `CHK(flags, 40'h07_2707_0703)
        acc(8'h02, 8'h15, 3'h0, 8'h01);
        acc(8'h10, 8'h16, 3'h5, 8'h00);
        acc(8'h20, 8'h15, 3'h1, 8'h00);
        acc(8'h08, 8'h3b, 3'h0, 8'h05);
        acc(8'h02, 8'h1c, 3'h0, 8'h00);
        `CHK(flags, 40'h06_0707_0203)
        rd_chk(8'h1b, 8'h02);
        // A set event in the clearing cycle must win
        @(posedge clk_in);
        flag_set_in.timer0 <= 8'h01;
        acc(8'h02, 8'h15, 3'h0, 8'h01);
        `CHK(flags.timer0, 8'h07)
        @(posedge clk_in);
        flag_set_in <= '0;
        // Refused, extended and unused-address accesses must leave the bank untouched
        for (int i = 0; i < 11; i++) begin
            acc(BAD_CMD[i], BAD_ADDR[i], 3'h2, 8'hff);
            `CHK({r.refused, r.ext_hit, r.rdata}, {BAD_CODE[i], 8'h00})
        end
        `CHK(rw_regs, 56'ha5_a527_28a9_aa03)
        give_verdict();
    end
endmodule
